/* File: include/dram_ctl_defines.svh */
// Register indices, field positions, reset values and timing counts of the DRAM controller
`ifndef DRAM_CTL_DEFINES_SVH
`define DRAM_CTL_DEFINES_SVH

// ---------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ---------------------------------------------------------------------------
`define DRC_IDX_B0_HIGH      28'hfffffe0
`define DRC_IDX_B0_LOW       28'hfffffe2
`define DRC_IDX_B1_HIGH      28'hfffffe4
`define DRC_IDX_B1_LOW       28'hfffffe6
`define DRC_IDX_REFRESH      28'hfffffe8
`define DRC_IDX_CS_WAIT      28'hfffffea
`define DRC_IDX_STATUS       28'hfffffec

// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define DRC_WRITE_PERMIT_BIT 0
`define DRC_BASE_MSB         15
`define DRC_READ_PERMIT_BIT  15
`define DRC_FC6_BIT          14
`define DRC_FC5_BIT          13
`define DRC_FC2_BIT          10
`define DRC_FC1_BIT          9
`define DRC_MATCH_MSB        7
`define DRC_MATCH_LSB        4
`define DRC_SIZE_MSB         3
`define DRC_SIZE_LSB         1
`define DRC_WAIT_BIT         0

// ---------------------------------------------------------------------------
// Reset values, codes and timing
// ---------------------------------------------------------------------------
`define DRC_REFRESH_RESET    8'hff
`define DRC_CS_EXT_CODE      4'hf
`define DRC_REFRESH_STEP     16
`define DRC_ROW_BASE_SHIFT   9

`endif

/* File: include/dram_ctl_pkg.sv */
// Types shared by the DRAM bank decode and refresh controller
package dram_ctl_pkg;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ROW, ST_COL, ST_ACK, ST_REF_CAS, ST_REF_RAS, ST_REF_END, ST_CS_CNT, ST_CS_EXT
  } ctl_state_t;

  typedef struct packed {
    logic        start;     // One-cycle pulse: a bus cycle begins
    logic [31:1] addr;      // Word address
    logic        write;     // 1 = write
    logic        test_and_set_op; // Write part of an indivisible test-and-set
    logic [1:0]  be;        // [1] upper byte, [0] lower byte
    logic [2:0]  fc;        // Function code
    logic [7:0]  cs_hit;    // Chip-select decodes, index 0 first
  } cpu_req_t;

  typedef struct packed {
    logic [14:0] muxed_memory_address;
    logic [1:0]  ras_n;
    logic        upper_byte_column_strobe_n;
    logic        lower_byte_column_strobe_n;
    logic        memory_write_strobe_n;
  } dram_pins_t;

  typedef struct packed {
    ctl_state_t  st;
    cpu_req_t    req;
    logic        held;
    logic        bank;
    logic [3:0]  cnt;
    dram_pins_t  pins;
    logic        transfer_acknowledge;
    logic        refresh_active;
    logic        pending;
    logic [7:0]  period;
    logic [7:0]  tmr;
    logic [3:0]  pre;
    logic [15:0] xdiv;
    logic        wb_ack;
    logic [31:0] wb_dat;
  } ctl_regs_t;

endpackage : dram_ctl_pkg

/* File: rtl/dram_bank_decode_refresh.sv */
// DRAM bank decode, address multiplexer, automatic acknowledge and refresh timer
//
// Contract
// - Refresh requests repeat every 16 to 4096 crystal periods, in steps of 16.
// - Refresh period is sixteen times (period field plus one) crystal periods.
// - Bank configuration registers keep their contents through every reset.
// - High half holds base bits A31..A17 in 15..1, write permit in 0.
// - Write permit 0 blocks writes; read and write both blocked disables bank.
// - Read permit at low bit 15 blocks reads when 0.
// - Function codes 6,5,2,1 enabled by low bits 14,13,10,9; none disables bank.
// - Match width at low bits 7..4 compares that many top bits from A31.
// - A nonzero base bit outside the compared range prevents any match.
// - Column address carries eight plus size-field bits; size at low bits 3..1.
// - Size and wait settings come from bank 0 only; bank 1 fields ignored.
// - Wait select 0 gives zero wait states, 1 gives one wait state.
// - Write part of a test-and-set to DRAM always has zero wait states.
// - Chip selects auto-acknowledge after 0 to 14 waits or use external acknowledge.
// - Chip-select test-and-set write lasts like an ordinary write there.
// - Row phase drives fifteen contiguous address bits on the muxed lines.
// - Writing refresh period restarts the timer and refreshes at once.
// - Chip selects beat bank 0, bank 0 beats bank 1.
// - DRAM accesses ignore external acknowledge; always acknowledged internally.
// - First column strobe drives upper byte, second the lower byte.
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
`include "dram_ctl_defines.svh"

module dram_bank_decode_refresh #(
  parameter int unsigned XTAL_DIV = 1  // Clock cycles per crystal period
) (
  input  wire logic                    clk,      // 100 MHz clock
  input  wire logic                    rst_n,    // Asynchronous reset, active low
  input  wire logic                    wb_cyc,   // Wishbone cycle
  input  wire logic                    wb_stb,   // Wishbone strobe
  input  wire logic                    wb_we,    // Wishbone write enable
  input  wire logic [31:0]             wb_adr,   // Wishbone byte address
  input  wire logic [3:0]              wb_sel,   // Wishbone byte selects
  input  wire logic [31:0]             wb_dat_w, // Wishbone write data
  output logic      [31:0]             wb_dat_r, // Wishbone read data
  output logic                         wb_ack,   // Wishbone acknowledge
  input  wire dram_ctl_pkg::cpu_req_t  cpu_req,  // Core bus request
  input  wire logic                    ext_ack,  // External acknowledge for chip selects
  output dram_ctl_pkg::dram_pins_t     dram,     // DRAM pins
  output logic                         transfer_acknowledge, // Automatic acknowledge pulse
  output logic                         refresh_active        // Refresh cycle under way
);
  import dram_ctl_pkg::*;

  // -------------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------------
  function automatic logic bank_match(input logic [15:0] hi, input logic [15:0] lo, input logic [31:1] a);
    logic ok;
    logic [3:0] w;
    ok = 1'b1;
    w  = lo[`DRC_MATCH_MSB:`DRC_MATCH_LSB];
    for (int i = 0; i < 15; i++)
    begin
      if (4'(i) < w)
      begin
        if (hi[`DRC_BASE_MSB - i] != a[31 - i])
          ok = 1'b0;
      end
      else if (hi[`DRC_BASE_MSB - i])
        ok = 1'b0;
    end
    return ok;
  endfunction : bank_match

  function automatic logic bank_permit(input logic [15:0] hi, input logic [15:0] lo, input logic wr,
                                       input logic [2:0] fc);
    logic rw_ok;
    logic fc_ok;
    rw_ok = wr ? hi[`DRC_WRITE_PERMIT_BIT] : lo[`DRC_READ_PERMIT_BIT];
    unique case (fc)
      3'h6:    fc_ok = lo[`DRC_FC6_BIT];
      3'h5:    fc_ok = lo[`DRC_FC5_BIT];
      3'h2:    fc_ok = lo[`DRC_FC2_BIT];
      3'h1:    fc_ok = lo[`DRC_FC1_BIT];
      default: fc_ok = 1'b0;
    endcase
    return rw_ok & fc_ok;
  endfunction : bank_permit

  function automatic logic [14:0] row_address(input logic [31:1] a, input logic [2:0] sz);
    logic [31:0] full;
    full = {a, 1'b0} >> (`DRC_ROW_BASE_SHIFT + int'(sz));
    return full[14:0];
  endfunction : row_address

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  // -------------------------------------------------------------------------
  // Configuration storage: deliberately no reset, contents random at power-up
  // -------------------------------------------------------------------------
  logic [15:0] b0_hi;
  logic [15:0] b0_lo;
  logic [15:0] b1_hi;
  logic [15:0] b1_lo;
  logic [31:0] cs_wait;

  ctl_regs_t   s;
  ctl_regs_t   next_s;
  logic        wr_en;
  logic [27:0] idx;
  logic        sel0;
  logic        sel1;
  logic [3:0]  cs_code;
  logic        ws;
  logic        xtick;
  logic        fire;

  assign idx   = wb_adr[29:2];
  assign wr_en = wb_cyc & wb_stb & wb_we & s.wb_ack;

  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      unique case (idx)
        `DRC_IDX_B0_HIGH: b0_hi <= merge16(b0_hi, wb_dat_w, wb_sel);
        `DRC_IDX_B0_LOW:  b0_lo <= merge16(b0_lo, wb_dat_w, wb_sel);
        `DRC_IDX_B1_HIGH: b1_hi <= merge16(b1_hi, wb_dat_w, wb_sel);
        `DRC_IDX_B1_LOW:  b1_lo <= merge16(b1_lo, wb_dat_w, wb_sel);
        `DRC_IDX_CS_WAIT:
        begin
          for (int b = 0; b < 4; b++)
            if (wb_sel[b])
              cs_wait[8*b +: 8] <= wb_dat_w[8*b +: 8];
        end
        default: ;
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // Decode of the held request
  // -------------------------------------------------------------------------
  always_comb
  begin
    // Match alone is not enough: a blocked bank lets the access fall through
    sel0 = bank_match(b0_hi, b0_lo, s.req.addr) & bank_permit(b0_hi, b0_lo, s.req.write, s.req.fc);
    sel1 = ~sel0 & bank_match(b1_hi, b1_lo, s.req.addr)
           & bank_permit(b1_hi, b1_lo, s.req.write, s.req.fc);
    cs_code = `DRC_CS_EXT_CODE;
    for (int c = 7; c >= 0; c--)
      if (s.req.cs_hit[c])
        cs_code = cs_wait[4*c +: 4];
    ws = b0_lo[`DRC_WAIT_BIT] & ~s.req.test_and_set_op;
  end

  assign xtick = (s.xdiv == 16'(XTAL_DIV - 1));
  assign fire  = xtick && (s.pre == 4'(`DRC_REFRESH_STEP - 1)) && (s.tmr == 8'h00);

  // -------------------------------------------------------------------------
  // Next-state logic
  // -------------------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    next_s.transfer_acknowledge = 1'b0;

    // Register bus: one-wait answer, unmapped reads return zero
    next_s.wb_ack = wb_cyc & wb_stb & ~s.wb_ack;
    next_s.wb_dat = 32'h0;
    unique case (idx)
      `DRC_IDX_B0_HIGH: next_s.wb_dat = {16'h0, b0_hi};
      `DRC_IDX_B0_LOW:  next_s.wb_dat = {16'h0, b0_lo};
      `DRC_IDX_B1_HIGH: next_s.wb_dat = {16'h0, b1_hi};
      `DRC_IDX_B1_LOW:  next_s.wb_dat = {16'h0, b1_lo};
      `DRC_IDX_REFRESH: next_s.wb_dat = {24'h0, s.period};
      `DRC_IDX_CS_WAIT: next_s.wb_dat = cs_wait;
      `DRC_IDX_STATUS:  next_s.wb_dat = {24'h0, s.st, s.held, s.bank, s.refresh_active, s.pending};
      default:          next_s.wb_dat = 32'h0;
    endcase

    // Refresh timer: 16 crystal periods per step of the period field
    next_s.xdiv = xtick ? 16'h0 : s.xdiv + 16'h1;
    if (xtick)
    begin
      next_s.pre = s.pre + 4'h1;
      if (s.pre == 4'(`DRC_REFRESH_STEP - 1))
        next_s.tmr = (s.tmr == 8'h00) ? s.period : s.tmr - 8'h1;
    end
    if (wr_en && idx == `DRC_IDX_REFRESH && wb_sel[0])
    begin
      next_s.period = wb_dat_w[7:0];
      next_s.tmr    = wb_dat_w[7:0];
      next_s.pre    = 4'h0;
      next_s.xdiv   = 16'h0;
    end

    // Request capture: a start arriving while busy waits here
    if (cpu_req.start)
    begin
      next_s.req  = cpu_req;
      next_s.held = 1'b1;
    end

    unique case (s.st)
      ST_IDLE:
      begin
        if (s.pending)
        begin
          next_s.st             = ST_REF_CAS;
          next_s.refresh_active = 1'b1;
          next_s.pins.upper_byte_column_strobe_n = 1'b0;
          next_s.pins.lower_byte_column_strobe_n = 1'b0;
        end
        else if (s.held)
        begin
          next_s.held = cpu_req.start;
          if (|s.req.cs_hit)
          begin
            next_s.cnt = cs_code;
            next_s.st  = (cs_code == `DRC_CS_EXT_CODE) ? ST_CS_EXT : ST_CS_CNT;
          end
          else if (sel0 | sel1)
          begin
            next_s.bank = sel1;
            next_s.st   = ST_ROW;
            next_s.pins.muxed_memory_address = row_address(s.req.addr, b0_lo[`DRC_SIZE_MSB:`DRC_SIZE_LSB]);
            next_s.pins.ras_n = sel1 ? 2'b01 : 2'b10;
          end
        end
      end
      ST_ROW:
      begin
        next_s.st  = ST_COL;
        next_s.cnt = {3'h0, ws};
        next_s.pins.muxed_memory_address = s.req.addr[15:1];
        next_s.pins.upper_byte_column_strobe_n = ~s.req.be[1];
        next_s.pins.lower_byte_column_strobe_n = ~s.req.be[0];
        next_s.pins.memory_write_strobe_n      = ~s.req.write;
      end
      ST_COL:
      begin
        if (s.cnt == 4'h0)
        begin
          next_s.transfer_acknowledge = 1'b1;
          next_s.st = ST_ACK;
        end
        else
          next_s.cnt = s.cnt - 4'h1;
      end
      ST_ACK:
      begin
        next_s.st   = ST_IDLE;
        next_s.pins.ras_n = 2'b11;
        next_s.pins.upper_byte_column_strobe_n = 1'b1;
        next_s.pins.lower_byte_column_strobe_n = 1'b1;
        next_s.pins.memory_write_strobe_n      = 1'b1;
      end
      ST_REF_CAS:
      begin
        // Both banks and both bytes refresh together, column strobe first
        next_s.st         = ST_REF_RAS;
        next_s.pins.ras_n = 2'b00;
      end
      ST_REF_RAS:
      begin
        next_s.st         = ST_REF_END;
        next_s.pins.upper_byte_column_strobe_n = 1'b1;
        next_s.pins.lower_byte_column_strobe_n = 1'b1;
      end
      ST_REF_END:
      begin
        next_s.st             = ST_IDLE;
        next_s.pins.ras_n     = 2'b11;
        next_s.refresh_active = 1'b0;
      end
      ST_CS_CNT:
      begin
        if (s.cnt == 4'h0)
        begin
          next_s.transfer_acknowledge = 1'b1;
          next_s.st = ST_IDLE;
        end
        else
          next_s.cnt = s.cnt - 4'h1;
      end
      ST_CS_EXT:
      begin
        // The device drives no acknowledge; the external one ends the cycle
        if (ext_ack)
          next_s.st = ST_IDLE;
      end
      default: next_s.st = ST_IDLE;
    endcase

    // A refresh taken in this cycle cannot swallow a new timer event
    if (s.st == ST_IDLE && s.pending)
      next_s.pending = 1'b0;
    if (fire || (wr_en && idx == `DRC_IDX_REFRESH && wb_sel[0]))
      next_s.pending = 1'b1;
  end

  // -------------------------------------------------------------------------
  // State register
  // -------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s        <= '0;
      s.st     <= ST_IDLE;
      s.period <= `DRC_REFRESH_RESET;
      s.tmr    <= `DRC_REFRESH_RESET;
      s.pins   <= '{muxed_memory_address: 15'h0, ras_n: 2'b11, upper_byte_column_strobe_n: 1'b1,
                    lower_byte_column_strobe_n: 1'b1, memory_write_strobe_n: 1'b1};
    end
    else
      s <= next_s;
  end

  assign wb_ack               = s.wb_ack;
  assign wb_dat_r             = s.wb_dat;
  assign dram                 = s.pins;
  assign transfer_acknowledge = s.transfer_acknowledge;
  assign refresh_active       = s.refresh_active;

  // -------------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------------
  logic [12:0] gap;
  logic        gap_ok;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gap    <= 13'h0;
      gap_ok <= 1'b0;
    end
    else if (wr_en && idx == `DRC_IDX_REFRESH)
    begin
      gap    <= 13'h0;
      gap_ok <= 1'b0;
    end
    else if (fire)
    begin
      gap    <= 13'h1;
      gap_ok <= (XTAL_DIV == 1);
    end
    else
      gap <= gap + 13'h1;
  end

  refresh_period_a: assert property (@(posedge clk) disable iff (!rst_n)
    (fire && gap_ok) |-> (gap == 13'(`DRC_REFRESH_STEP * (int'(s.period) + 1))))
    else $error("refresh period differs from sixteen times field plus one");
  refresh_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_en && idx == `DRC_IDX_REFRESH && wb_sel[0] && s.st != ST_IDLE) |=> s.pending)
    else $error("refresh period write did not request a refresh");
  refresh_seq_a: assert property (@(posedge clk) disable iff (!rst_n)
    (s.st == ST_IDLE && s.pending) |=> (s.pins.upper_byte_column_strobe_n == 1'b0 && s.pins.ras_n == 2'b11)
    ##1 (s.pins.ras_n == 2'b00) ##1 (s.pins.upper_byte_column_strobe_n && s.pins.ras_n == 2'b00)
    ##1 (s.pins.ras_n == 2'b11))
    else $error("refresh cycle not column before row");
  rmw_zero_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
    (s.st == ST_ROW && s.req.test_and_set_op) |=> ##1 s.transfer_acknowledge)
    else $error("test-and-set write to DRAM was not zero wait");
  one_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
    (s.st == ST_ROW && !s.req.test_and_set_op && b0_lo[`DRC_WAIT_BIT]) |=> ##1 !s.transfer_acknowledge
    ##1 s.transfer_acknowledge)
    else $error("one wait state DRAM timing wrong");
  cs_priority_a: assert property (@(posedge clk) disable iff (!rst_n)
    (s.st == ST_IDLE && !s.pending && s.held && |s.req.cs_hit) |=> (s.pins.ras_n == 2'b11 && s.st inside
    {ST_CS_CNT, ST_CS_EXT}))
    else $error("chip select lost priority to DRAM");
  blocked_bank_a: assert property (@(posedge clk) disable iff (!rst_n)
    (s.st == ST_IDLE && !s.pending && s.held && !(|s.req.cs_hit) && !sel0 && !sel1) |=> s.st == ST_IDLE)
    else $error("blocked bank started a DRAM cycle");
  column_phase_a: assert property (@(posedge clk) disable iff (!rst_n)
    (s.st == ST_COL) |-> (s.pins.muxed_memory_address == s.req.addr[15:1]
    && s.pins.upper_byte_column_strobe_n == !s.req.be[1] && s.pins.lower_byte_column_strobe_n == !s.req.be[0]))
    else $error("column phase address or byte strobes wrong");
  row_phase_a: assert property (@(posedge clk) disable iff (!rst_n)
    (s.st == ST_ROW) |-> (s.pins.muxed_memory_address
    == row_address(s.req.addr, b0_lo[`DRC_SIZE_MSB:`DRC_SIZE_LSB])))
    else $error("row address not contiguous upper bits");
  ext_only_cs_a: assert property (@(posedge clk) disable iff (!rst_n)
    (s.st == ST_CS_EXT) |-> (s.pins.ras_n == 2'b11 && !s.transfer_acknowledge))
    else $error("external acknowledge path used for DRAM");
  wb_ack_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
    s.wb_ack |=> !s.wb_ack)
    else $error("bus acknowledge longer than one cycle");

  refresh_seen_c: cover property (@(posedge clk) disable iff (!rst_n) s.st == ST_REF_END);
  dram_wait_c:    cover property (@(posedge clk) disable iff (!rst_n) s.st == ST_COL && s.cnt == 4'h1);
  cs_ext_c:       cover property (@(posedge clk) disable iff (!rst_n) s.st == ST_CS_EXT && ext_ack);
  rmw_dram_c:     cover property (@(posedge clk) disable iff (!rst_n) s.st == ST_ROW && s.req.test_and_set_op);

endmodule : dram_bank_decode_refresh

/* File: sim/dram_pair_model.sv */
// Passive model of the two external DRAM banks, recording each strobed address
`timescale 1ns/1ps

module dram_pair_model (
  input  wire logic                     clk,    // Controller clock
  input  wire dram_ctl_pkg::dram_pins_t dram,   // Controller pins
  output logic [14:0]                   row_q,  // Last row address
  output logic [14:0]                   col_q,  // Last column address
  output logic [1:0]                    bank_q, // Banks opened by the last row strobe
  output logic [1:0]                    lane_q, // Lanes strobed {upper, lower}
  output logic                          wr_q,   // Last column phase was a write
  output int                            opens   // Row strobe falls with column strobes high
);
  import dram_ctl_pkg::*;
  logic       cas_hi;
  logic [1:0] ras_d;

  // Refresh drops the column strobes first, so it never counts as an open
  assign cas_hi = dram.upper_byte_column_strobe_n & dram.lower_byte_column_strobe_n;
  initial opens = 0;

  always @(posedge clk)
  begin
    ras_d <= dram.ras_n;
    if (dram.ras_n != 2'b11 && ras_d == 2'b11 && cas_hi)
    begin
      row_q  <= dram.muxed_memory_address;
      bank_q <= ~dram.ras_n;
      opens  <= opens + 1;
    end
    if (!cas_hi && dram.ras_n != 2'b11)
    begin
      col_q  <= dram.muxed_memory_address;
      lane_q <= ~{dram.upper_byte_column_strobe_n, dram.lower_byte_column_strobe_n};
      wr_q   <= ~dram.memory_write_strobe_n;
    end
  end
endmodule : dram_pair_model

/* File: sim/tb.sv */
// Self-checking bench for the DRAM bank decode and refresh controller
`timescale 1ns/1ps
`include "dram_ctl_defines.svh"

module tb;
  import dram_ctl_pkg::*;
  localparam logic [31:0] A = 32'h00a5_c3e4;
  localparam logic [31:0] B = 32'h80a5_c3e4;
  logic        clk, rst_n, wb_cyc, wb_stb, wb_we, wb_ack, ext_ack, tack, ref_on, wr_q;
  logic [31:0] wb_adr, wb_dat_w, wb_dat_r, rd;
  logic [3:0]  wb_sel;
  logic [14:0] row_q, col_q;
  logic [1:0]  bank_q, lane_q;
  cpu_req_t    req;
  dram_pins_t  dram;
  int          opens, error_cnt, n_compared, lat, n0;

  dram_bank_decode_refresh #(.XTAL_DIV(1)) dut (.clk(clk), .rst_n(rst_n), .wb_cyc(wb_cyc),
    .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
    .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .cpu_req(req), .ext_ack(ext_ack), .dram(dram),
    .transfer_acknowledge(tack), .refresh_active(ref_on));
  dram_pair_model partner (.clk(clk), .dram(dram), .row_q(row_q), .col_q(col_q), .bank_q(bank_q),
    .lane_q(lane_q), .wr_q(wr_q), .opens(opens));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out

  // Classic single cycle; request held until ack is sampled high at a rising edge, released there
  task automatic wb(input logic we, input logic [27:0] idx, input logic [31:0] d);
    int n;
    @(posedge clk);
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= we;
    wb_adr   <= {2'b00, idx, 2'b00};
    wb_dat_w <= d;
    wb_sel   <= 4'hf;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (wb_ack !== 1'b1);
    rd = wb_dat_r;
    chk("wb_ack wait", n, 2);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : wb

  // Latency is the cycle, counted from the start cycle, holding the acknowledge
  task automatic acc(input logic [31:0] a, input logic w, input logic t, input logic [1:0] be,
                     input logic [2:0] fc, input logic [7:0] cs);
    @(posedge clk);
    req <= '{start: 1'b1, addr: a[31:1], write: w, test_and_set_op: t, be: be, fc: fc, cs_hit: cs};
    lat = -1;
    for (int n = 0; n < 20 && lat < 0; n++)
    begin
      @(negedge clk);
      if (tack === 1'b1)
        lat = n;
      @(posedge clk);
      req.start <= 1'b0;
    end
  endtask : acc

  task automatic next_ref(input int lim);
    logic pv;
    logic rise;
    // Start from the present level so a refresh already under way is not counted
    pv  = ref_on;
    lat = 0;
    do
    begin
      @(negedge clk);
      lat++;
      rise = (ref_on === 1'b1) && (pv !== 1'b1);
      pv   = ref_on;
    end while (!rise && lat < lim);
  endtask : next_ref

  initial
  begin
    #200000;
    error_cnt++;
    close_out();
  end

  // ---------------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0; wb_cyc = 1'b0; wb_stb = 1'b0; wb_we = 1'b0; wb_adr = '0; wb_sel = '0;
    wb_dat_w = '0; ext_ack = 1'b0; req = '0; error_cnt = 0; n_compared = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    wb(1, `DRC_IDX_B0_HIGH, 32'h0001);
    wb(1, `DRC_IDX_B0_LOW, 32'he600);
    wb(1, `DRC_IDX_B1_HIGH, 32'h0000);
    wb(1, `DRC_IDX_B1_LOW, 32'h0000);
    wb(1, `DRC_IDX_CS_WAIT, 32'h0f50);
    wb(1, `DRC_IDX_REFRESH, 32'hff);
    repeat (10) @(posedge clk);
    acc(A, 0, 0, 2'b10, 3'd5, 8'h00); chk("lat rd ws0", lat, 4);
    chk("row", row_q, A[23:9]);
    chk("col", col_q, A[15:1]);
    chk("lanes", lane_q, 2'b10);
    acc(A, 1, 0, 2'b01, 3'd6, 8'h00); chk("lanes", lane_q, 2'b01);
    chk("write", wr_q, 1);
    ext_ack <= 1'b1;
    acc(A, 0, 0, 2'b11, 3'd1, 8'h00); chk("lat ext", lat, 4);
    ext_ack <= 1'b0;
    wb(1, `DRC_IDX_B0_LOW, 32'he607);
    acc(A, 0, 0, 2'b11, 3'd2, 8'h00); chk("lat rd ws1", lat, 5);
    chk("row sz3", row_q, A[26:12]);
    acc(A, 1, 1, 2'b11, 3'd5, 8'h00); chk("lat tas", lat, 4);
    for (int f = 0; f < 8; f++)
    begin
      acc(A, 0, 0, 2'b11, f[2:0], 8'h00); chk("lat fc", lat, (f % 4 == 1 || f % 4 == 2) ? 5 : -1);
    end
    wb(1, `DRC_IDX_B0_LOW, 32'h6601);
    acc(A, 0, 0, 2'b11, 3'd5, 8'h00); chk("lat no rd", lat, -1);
    acc(A, 1, 0, 2'b11, 3'd5, 8'h00); chk("lat wr", lat, 5);
    wb(1, `DRC_IDX_B0_LOW, 32'he601);
    wb(1, `DRC_IDX_B0_HIGH, 32'h0000);
    acc(A, 1, 0, 2'b11, 3'd5, 8'h00); chk("lat no wr", lat, -1);
    wb(1, `DRC_IDX_B0_HIGH, 32'h8001);
    wb(0, `DRC_IDX_B0_HIGH, 0); chk("b0 high", rd, 32'h8001);
    acc(B, 0, 0, 2'b11, 3'd5, 8'h00); chk("lat stray base", lat, -1);
    wb(1, `DRC_IDX_B0_LOW, 32'he611);
    acc(A, 0, 0, 2'b11, 3'd5, 8'h00); chk("lat miss", lat, -1);
    acc(B, 0, 0, 2'b11, 3'd5, 8'h00); chk("lat hit", lat, 5);
    wb(1, `DRC_IDX_B1_HIGH, 32'h0001);
    wb(1, `DRC_IDX_B1_LOW, 32'he600);
    acc(A, 0, 0, 2'b11, 3'd5, 8'h00); chk("lat b1", lat, 5);
    chk("bank b1", bank_q, 2'b10);
    acc(B, 0, 0, 2'b11, 3'd5, 8'h00); chk("bank both", bank_q, 2'b01);
    n0 = opens;
    acc(A, 0, 0, 2'b11, 3'd5, 8'h02); chk("lat cs1", lat, 8);
    acc(A, 1, 1, 2'b11, 3'd5, 8'h06); chk("lat cs tas", lat, 8);
    acc(A, 0, 0, 2'b11, 3'd5, 8'h01); chk("lat cs0", lat, 3);
    acc(A, 0, 0, 2'b11, 3'd5, 8'h04); chk("lat cs ext", lat, -1);
    chk("no row", opens, n0);
    ext_ack <= 1'b1;
    repeat (2) @(posedge clk);
    ext_ack <= 1'b0;
    acc(A, 0, 0, 2'b11, 3'd5, 8'h00); chk("lat after ext", lat, 5);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    wb(0, `DRC_IDX_B0_LOW, 0); chk("b0 low kept", rd, 32'he611);
    wb(0, `DRC_IDX_B1_HIGH, 0); chk("b1 high kept", rd, 32'h0001);
    wb(0, 28'h0000010, 0); chk("unmapped", rd, 0);
    for (int v = 0; v < 3; v++)
    begin
      n0 = (v == 2) ? 255 : v;
      wb(1, `DRC_IDX_REFRESH, n0);
      next_ref(6); chk("refresh now", lat < 6, 1);
      next_ref(5000); chk("refresh period", lat, 16 * (n0 + 1));
    end
    close_out();
  end
endmodule : tb
